// ===== logic/csw_cs_gate.sv
// Purpose: chip-select gating that blocks memory selects while reset is held
// Assumes: reset_active and cs_in_n are synchronous levels
// Notes: an access already running when reset strikes gets a short grace
`timescale 1ns/100ps
module csw_cs_gate (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic reset_active,
  input wire logic cs_in_n,
  output logic cs_out_n
);

  logic rst_prev_reg;
  logic grace_reg;
  logic [7:0] grace_cnt_reg;
  logic rise;
  logic grace_end;

  assign rise = reset_active && !rst_prev_reg;
  assign grace_end = cs_in_n || (grace_cnt_reg == 8'(csw_pkg::CS_HOLD_CYC - 1));

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_prev_reg <= 1'b1;
    end else begin
      rst_prev_reg <= reset_active;
    end
  end

  // grace starts only if the select is low at the moment reset asserts
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      grace_reg <= 1'b0;
      grace_cnt_reg <= 8'h00;
    end else if (rise && !cs_in_n) begin
      grace_reg <= 1'b1; // [RULE_14]
      grace_cnt_reg <= 8'h00;
    end else if (grace_reg && (grace_end || !reset_active)) begin
      grace_reg <= 1'b0; // [RULE_14]
      grace_cnt_reg <= 8'h00;
    end else if (grace_reg) begin
      grace_cnt_reg <= grace_cnt_reg + 8'h01;
    end
  end

  // during reset the input is isolated except for the grace window
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cs_out_n <= 1'b1;
    end else begin
      cs_out_n <= !(!cs_in_n && (!reset_active || rise ||
                   (grace_reg && !grace_end))); // [RULE_13] [RULE_18]
    end
  end

endmodule

// ===== logic/csw_pkg.sv
// Purpose: shared constants for the cpu supervisor and watchdog block
// Assumes: one free-running 10 MHz clock, analog comparators seen as levels
// Notes: every time is kept in its own unit and converted to clock cycles here
package csw_pkg;

  localparam int CLK_HZ = 10_000_000;
  localparam int CLK_PERIOD_NS = 100;

  // reset stretch after the reset condition clears (typical figure)
  localparam int STRETCH_MS = 200;
  localparam int STRETCH_CYC = (STRETCH_MS * 1_000_000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // default watchdog timeout with the timeout select tied to supply
  localparam real WD_DEFAULT_SEC = 1.6;
  localparam int WD_DEFAULT_CYC = int'(WD_DEFAULT_SEC * CLK_HZ);

  // capacitor-programmed timeout: milliseconds per nanofarad
  localparam real WD_K_5V = 27.0;
  localparam real WD_K_3V = 16.2;
  localparam int WD_K_5V_CYC = int'(WD_K_5V * CLK_HZ / 1000.0);
  localparam int WD_K_3V_CYC = int'(WD_K_3V * CLK_HZ / 1000.0);

  // least width of the warning pulse, rounded up
  localparam int WARN_PULSE_US = 500;
  localparam int WARN_PULSE_CYC = (WARN_PULSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // lead of the warning pulse over the fault output, rounded up
  localparam int WARN_LEAD_NS = 70;
  localparam int WARN_LEAD_CYC = (WARN_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // manual-reset low to reset asserted (typical figure)
  localparam int MAN_DELAY_US = 12;
  localparam int MAN_DELAY_CYC = (MAN_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // least hold of the manual-reset input by the driving party
  localparam int MAN_MIN_US = 25;
  localparam int MAN_MIN_CYC = (MAN_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // longest grace for an in-flight chip select, rounded down
  localparam int CS_HOLD_US = 15;
  localparam int CS_HOLD_CYC = (CS_HOLD_US * 1000) / CLK_PERIOD_NS;

  localparam int WD_CNT_W = 40;
  localparam int CAP_W = 16;

  // index of each comparator and pin level in the synchroniser bank
  localparam int SY_SUPPLY_LOW = 0;
  localparam int SY_RSENSE_LOW = 1;
  localparam int SY_MODE_EXT = 2;
  localparam int SY_LOWLINE = 3;
  localparam int SY_LLSENSE_LOW = 4;
  localparam int SY_OVER = 5;
  localparam int SY_TSEL = 6;
  localparam int SY_LOW3V = 7;
  localparam int SY_MAN_N = 8;
  localparam int SY_KICK = 9;
  localparam int SY_CS_N = 10;
  localparam int SY_W = 11;
  localparam logic [SY_W-1:0] SY_RESET_VAL = 11'h500;

  typedef enum logic [1:0] {
    CSW_ST_HOLD = 2'b00,
    CSW_ST_STRETCH = 2'b01,
    CSW_ST_RUN = 2'b10
  } csw_state_e;

endpackage

// ===== logic/csw_sync.sv
// Purpose: two-flop synchroniser bank for comparator and pin levels
// Assumes: each bit is an independent level
// Notes: the first stage is read by the second stage only
`timescale 1ns/100ps
module csw_sync (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [csw_pkg::SY_W-1:0] d,
  output logic [csw_pkg::SY_W-1:0] q
);

  logic [csw_pkg::SY_W-1:0] meta_reg;

  // reset value matches the idle pin levels so nothing fires on release
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= csw_pkg::SY_RESET_VAL;
      q <= csw_pkg::SY_RESET_VAL;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule

// ===== logic/csw_top.sv
// Purpose: microprocessor supervisor: reset generation, watchdog, supply
//          warning, overvoltage flag and chip-select gating
// Assumes: analog comparator results arrive as digital levels; one
//          free-running clock; rst_n is the power-up state
// Notes: stretch, default watchdog and warning pulse counts are top-level parameters so simulation can shorten them
`timescale 1ns/100ps

// What this block does
// RULE_01: reset low when supply low (internal) or reset sense below threshold (external).
// RULE_02: after condition clears, keep reset asserted for the stretch time.
// RULE_03: active-high reset always the exact complement of active-low reset.
// RULE_04: mode sense grounded selects internal mode, raised selects external mode.
// RULE_05: supply warning low on low-line level, per mode.
// RULE_06: overvoltage flag low while sense high; touches nothing else.
// RULE_07: timeout select tied high gives the default watchdog timeout.
// RULE_08: capacitor timeout scales with nanofarads, factor 27 at 5V, 16.2 at 3V.
// RULE_09: fault output low once kick holds one level past the timeout.
// RULE_10: fault output returns high at the next kick transition.
// RULE_11: warning pulse low for at least its minimum width on timeout.
// RULE_12: warning pulse starts ahead of the fault output falling.
// RULE_13: gated select low only while select input low and reset not asserted.
// RULE_14: select low at reset assertion stays low for grace or until it rises.
// RULE_15: manual reset held low long enough asserts reset after a short delay.
// RULE_16: reset held while manual reset low; stretch starts after it rises.
// RULE_17: manual reset active when low; undriven input reads as inactive high.
// RULE_18: during reset counters clear, watchdog outputs high, select gated high.
// RULE_19: in internal mode supply warning asserts no later than reset.
// RULE_20: intervals are clock counts set by parameters; levels are synchronised.
// RULE_21: watchdog count restarts on every kick edge and on reset release.
module csw_top #(
  parameter int STRETCH_CYC = csw_pkg::STRETCH_CYC,
  parameter int WD_DEFAULT_CYC = csw_pkg::WD_DEFAULT_CYC,
  parameter int WARN_PULSE_CYC = csw_pkg::WARN_PULSE_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic supply_below_thr,
  input wire logic reset_sense_below,
  input wire logic mode_sense_raised,
  input wire logic lowline_level,
  input wire logic supply_warning_sense,
  input wire logic overvoltage_sense,
  input wire logic timeout_select,
  input wire logic [csw_pkg::CAP_W-1:0] timeout_cap_nf,
  input wire logic supply_is_3v,
  input wire logic manual_reset_n,
  input wire logic manual_reset_driven,
  input wire logic watchdog_kick,
  input wire logic chip_sel_in_n,
  output logic reset_n,
  output logic reset_hi,
  output logic supply_warning_n,
  output logic overvoltage_flag_n,
  output logic watchdog_fault_n,
  output logic watchdog_warn_pulse_n,
  output logic chip_sel_out_n
);

  // capacitor-programmed timeout in cycles, never below one cycle
  function automatic logic [csw_pkg::WD_CNT_W-1:0] cap_limit(
    input logic [csw_pkg::CAP_W-1:0] nf,
    input logic low3v
  );
    logic [csw_pkg::WD_CNT_W-1:0] per_nf;
    logic [csw_pkg::WD_CNT_W-1:0] prod;
    per_nf = low3v ? csw_pkg::WD_CNT_W'(csw_pkg::WD_K_3V_CYC)
                   : csw_pkg::WD_CNT_W'(csw_pkg::WD_K_5V_CYC);
    prod = csw_pkg::WD_CNT_W'(nf) * per_nf; // [RULE_08]
    if (prod == '0) begin
      prod = csw_pkg::WD_CNT_W'(1);
    end
    return prod;
  endfunction

  logic [csw_pkg::SY_W-1:0] raw;
  logic [csw_pkg::SY_W-1:0] sy;
  logic man_level_n;

  // weak pull-up: a floating manual reset reads as inactive
  assign man_level_n = manual_reset_driven ? manual_reset_n : 1'b1; // [RULE_17]

  always_comb begin
    raw = '0;
    raw[csw_pkg::SY_SUPPLY_LOW] = supply_below_thr;
    raw[csw_pkg::SY_RSENSE_LOW] = reset_sense_below;
    raw[csw_pkg::SY_MODE_EXT] = mode_sense_raised;
    raw[csw_pkg::SY_LOWLINE] = lowline_level;
    raw[csw_pkg::SY_LLSENSE_LOW] = supply_warning_sense;
    raw[csw_pkg::SY_OVER] = overvoltage_sense;
    raw[csw_pkg::SY_TSEL] = timeout_select;
    raw[csw_pkg::SY_LOW3V] = supply_is_3v;
    raw[csw_pkg::SY_MAN_N] = man_level_n;
    raw[csw_pkg::SY_KICK] = watchdog_kick;
    raw[csw_pkg::SY_CS_N] = chip_sel_in_n;
  end

  csw_sync u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .d(raw),
    .q(sy) // [RULE_20]
  );

  logic mode_ext;
  logic supply_cond;
  logic kick_s;

  assign mode_ext = sy[csw_pkg::SY_MODE_EXT]; // [RULE_04]
  assign supply_cond = mode_ext ? sy[csw_pkg::SY_RSENSE_LOW]
                                : sy[csw_pkg::SY_SUPPLY_LOW]; // [RULE_01]
  assign kick_s = sy[csw_pkg::SY_KICK];

  // manual reset: qualify the low level for the propagation delay first
  logic [7:0] man_cnt_reg;
  logic man_taken;

  assign man_taken = (man_cnt_reg == 8'(csw_pkg::MAN_DELAY_CYC));

  // short glitches below the delay never reach reset; the far side holds
  // the input for at least MAN_MIN_CYC, well beyond the delay
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      man_cnt_reg <= 8'h00;
    end else if (sy[csw_pkg::SY_MAN_N]) begin
      man_cnt_reg <= 8'h00; // [RULE_16]
    end else if (!man_taken) begin
      man_cnt_reg <= man_cnt_reg + 8'h01; // [RULE_15]
    end
  end

  // reset sequencer
  csw_pkg::csw_state_e state_reg;
  csw_pkg::csw_state_e state_next;
  logic [31:0] stretch_cnt_reg;
  logic rst_cond;
  logic stretch_done;

  assign rst_cond = supply_cond || man_taken; // [RULE_01] [RULE_16]
  assign stretch_done = (stretch_cnt_reg == 32'(STRETCH_CYC - 1));

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      csw_pkg::CSW_ST_HOLD: begin
        if (!rst_cond) begin
          state_next = csw_pkg::CSW_ST_STRETCH;
        end
      end
      csw_pkg::CSW_ST_STRETCH: begin
        if (rst_cond) begin
          state_next = csw_pkg::CSW_ST_HOLD;
        end else if (stretch_done) begin
          state_next = csw_pkg::CSW_ST_RUN; // [RULE_02]
        end
      end
      csw_pkg::CSW_ST_RUN: begin
        if (rst_cond) begin
          state_next = csw_pkg::CSW_ST_HOLD;
        end
      end
      default: begin
        state_next = csw_pkg::CSW_ST_HOLD;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= csw_pkg::CSW_ST_HOLD;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stretch_cnt_reg <= 32'h0000_0000;
    end else if (state_reg == csw_pkg::CSW_ST_STRETCH && !rst_cond) begin
      stretch_cnt_reg <= stretch_cnt_reg + 32'h0000_0001; // [RULE_02]
    end else begin
      stretch_cnt_reg <= 32'h0000_0000;
    end
  end

  // both polarities come from the same next state, so they never disagree
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reset_n <= 1'b0;
      reset_hi <= 1'b1;
    end else begin
      reset_n <= (state_next == csw_pkg::CSW_ST_RUN); // [RULE_01]
      reset_hi <= (state_next != csw_pkg::CSW_ST_RUN); // [RULE_03]
    end
  end

  // supply warning and overvoltage flag
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      supply_warning_n <= 1'b1;
    end else if (mode_ext) begin
      supply_warning_n <= !sy[csw_pkg::SY_LLSENSE_LOW]; // [RULE_05]
    end else begin
      // the reset comparator also pulls the warning so it never trails reset
      supply_warning_n <= !(sy[csw_pkg::SY_LOWLINE] ||
                            sy[csw_pkg::SY_SUPPLY_LOW]); // [RULE_05] [RULE_19]
    end
  end

  // uncommitted comparator, deliberately wired to nothing else
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      overvoltage_flag_n <= 1'b1;
    end else begin
      overvoltage_flag_n <= !sy[csw_pkg::SY_OVER]; // [RULE_06]
    end
  end

  // watchdog
  logic kick_prev_reg;
  logic kick_edge;
  logic running;
  logic [csw_pkg::WD_CNT_W-1:0] wd_cnt_reg;
  logic [csw_pkg::WD_CNT_W-1:0] wd_limit;
  logic [csw_pkg::CAP_W-1:0] cap_reg;
  logic wd_hit;
  logic pend_reg;
  logic [3:0] lead_cnt_reg;
  logic lead_done;
  logic faulted;
  logic [15:0] warn_cnt_reg;

  assign running = reset_n;
  assign kick_edge = kick_s ^ kick_prev_reg;
  assign wd_limit = sy[csw_pkg::SY_TSEL] ? csw_pkg::WD_CNT_W'(WD_DEFAULT_CYC) // [RULE_07]
                                         : cap_limit(cap_reg, sy[csw_pkg::SY_LOW3V]);
  assign faulted = pend_reg || !watchdog_fault_n;
  assign wd_hit = running && !faulted && !kick_edge &&
                  (wd_cnt_reg >= wd_limit - csw_pkg::WD_CNT_W'(1)); // [RULE_09]
  assign lead_done = (lead_cnt_reg == 4'(csw_pkg::WARN_LEAD_CYC - 1));

  // capacitor value is quasi-static strap data, a single register is enough
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cap_reg <= '0;
      kick_prev_reg <= 1'b0;
    end else begin
      cap_reg <= timeout_cap_nf;
      kick_prev_reg <= kick_s;
    end
  end

  // count held at zero while faulted; the next kick edge restarts it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wd_cnt_reg <= '0;
    end else if (!running || kick_edge || faulted || wd_hit) begin
      wd_cnt_reg <= '0; // [RULE_18] [RULE_21]
    end else begin
      wd_cnt_reg <= wd_cnt_reg + csw_pkg::WD_CNT_W'(1);
    end
  end

  // warning pulse leads the fault by WARN_LEAD_CYC cycles
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pend_reg <= 1'b0;
      lead_cnt_reg <= 4'h0;
      watchdog_fault_n <= 1'b1;
    end else if (!running) begin
      pend_reg <= 1'b0; // [RULE_18]
      lead_cnt_reg <= 4'h0;
      watchdog_fault_n <= 1'b1;
    end else if (kick_edge) begin
      pend_reg <= 1'b0;
      lead_cnt_reg <= 4'h0;
      watchdog_fault_n <= 1'b1; // [RULE_10]
    end else if (wd_hit) begin
      pend_reg <= 1'b1;
      lead_cnt_reg <= 4'h0;
    end else if (pend_reg && lead_done) begin
      pend_reg <= 1'b0;
      watchdog_fault_n <= 1'b0; // [RULE_09] [RULE_12]
    end else if (pend_reg) begin
      lead_cnt_reg <= lead_cnt_reg + 4'h1;
    end
  end

  // pulse runs its full width even if the processor recovers meanwhile
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      watchdog_warn_pulse_n <= 1'b1;
      warn_cnt_reg <= 16'h0000;
    end else if (!running) begin
      watchdog_warn_pulse_n <= 1'b1; // [RULE_18]
      warn_cnt_reg <= 16'h0000;
    end else if (wd_hit) begin
      watchdog_warn_pulse_n <= 1'b0; // [RULE_11] [RULE_12]
      warn_cnt_reg <= 16'h0000;
    end else if (!watchdog_warn_pulse_n) begin
      if (warn_cnt_reg == 16'(WARN_PULSE_CYC - 1)) begin
        watchdog_warn_pulse_n <= 1'b1; // [RULE_11]
      end else begin
        warn_cnt_reg <= warn_cnt_reg + 16'h0001;
      end
    end
  end

  // chip-select gating
  csw_cs_gate u_cs_gate (
    .mclk(mclk),
    .rst_n(rst_n),
    .reset_active(!reset_n),
    .cs_in_n(sy[csw_pkg::SY_CS_N]),
    .cs_out_n(chip_sel_out_n) // [RULE_13] [RULE_14]
  );

endmodule

// ===== tb/csw_cpu_model.sv
// Purpose: processor side: watchdog kicks and memory chip select
// Assumes: the processor stalls while held in reset
// Notes: kick gap is well under the shortened watchdog timeout
`timescale 1ns/100ps
module csw_cpu_model #(
  parameter int KICK_GAP = 10
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic reset_n,
  input wire logic kick_en,
  input wire logic cs_req,
  input wire logic stray,
  output logic watchdog_kick,
  output logic chip_sel_in_n
);
  int gap;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gap <= 0;
      watchdog_kick <= 1'b0;
    end else if (kick_en && reset_n) begin
      gap <= (gap == KICK_GAP - 1) ? 0 : gap + 1;
      if (gap == KICK_GAP - 1) begin
        watchdog_kick <= ~watchdog_kick;
      end
    end
  end
  // a cycle in flight is kept into reset; new ones only when told to misbehave
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      chip_sel_in_n <= 1'b1;
    end else begin
      chip_sel_in_n <= ~(cs_req && (reset_n || !chip_sel_in_n || stray));
    end
  end
endmodule

// ===== tb/csw_monitor.sv
// Purpose: port-level checks on the supervisor top module
// Assumes: shortened interval parameters, one clock domain
// Notes: counters turn long waits into plain comparisons
`timescale 1ns/100ps
module csw_monitor #(
  parameter int STRETCH_CYC = 20,
  parameter int WD_DEFAULT_CYC = 50,
  parameter int WARN_PULSE_CYC = 8
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic supply_below_thr,
  input wire logic reset_sense_below,
  input wire logic mode_sense_raised,
  input wire logic lowline_level,
  input wire logic supply_warning_sense,
  input wire logic overvoltage_sense,
  input wire logic timeout_select,
  input wire logic [csw_pkg::CAP_W-1:0] timeout_cap_nf,
  input wire logic supply_is_3v,
  input wire logic manual_reset_n,
  input wire logic manual_reset_driven,
  input wire logic watchdog_kick,
  input wire logic chip_sel_in_n,
  input wire logic reset_n,
  input wire logic reset_hi,
  input wire logic supply_warning_n,
  input wire logic overvoltage_flag_n,
  input wire logic watchdog_fault_n,
  input wire logic watchdog_warn_pulse_n,
  input wire logic chip_sel_out_n
);
  logic cond;
  logic kick_q;
  int clr_cnt;
  int man_cnt;
  int low_cnt;
  int idle_cnt;
  // pin view of a reset cause; the design sees it a few cycles later
  assign cond = (mode_sense_raised ? reset_sense_below : supply_below_thr) |
                (manual_reset_driven & ~manual_reset_n);
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      kick_q <= 1'b0;
      clr_cnt <= 0;
      man_cnt <= 0;
      low_cnt <= 0;
      idle_cnt <= 0;
    end else begin
      kick_q <= watchdog_kick;
      clr_cnt <= cond ? 0 : clr_cnt + 1;
      man_cnt <= (manual_reset_driven && !manual_reset_n) ? man_cnt + 1 : 0;
      low_cnt <= reset_n ? 0 : low_cnt + 1;
      idle_cnt <= (!reset_n || watchdog_kick != kick_q) ? 0 : idle_cnt + 1;
    end
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  a_reset_compl: assert property (reset_hi != reset_n)
    else $error("reset outputs not complementary");
  a_int_reset: assert property ((!mode_sense_raised && supply_below_thr) [*5] |->
    !reset_n)
    else $error("low supply did not assert reset");
  a_ext_reset: assert property ((mode_sense_raised && reset_sense_below)
    [*5] |-> !reset_n)
    else $error("low reset sense did not assert reset");
  a_stretch_min: assert property ($rose(reset_n) |-> clr_cnt >= STRETCH_CYC)
    else $error("reset released before the stretch ran out");
  a_stretch_max: assert property (clr_cnt == STRETCH_CYC + 8 |-> reset_n)
    else $error("reset held too long after cause cleared");
  a_man_assert: assert property (man_cnt == 130 |-> !reset_n)
    else $error("manual reset not honoured");
  a_ov_flag: assert property ($stable(overvoltage_sense) [*5] |->
    overvoltage_flag_n == !overvoltage_sense)
    else $error("overvoltage flag wrong");
  a_warn_level: assert property ($stable({mode_sense_raised, lowline_level,
    supply_warning_sense, supply_below_thr}) [*5] |-> supply_warning_n == !(mode_sense_raised ?
    supply_warning_sense : lowline_level | supply_below_thr))
    else $error("supply warning wrong");
  a_warn_first: assert property ($fell(reset_n) && !mode_sense_raised && supply_below_thr
    |-> !supply_warning_n)
    else $error("reset came before warning");
  a_wd_idle_min: assert property ($fell(watchdog_fault_n) && timeout_select
    |-> idle_cnt >= WD_DEFAULT_CYC - 2)
    else $error("watchdog fault too early");
  a_wd_idle_max: assert property (idle_cnt == WD_DEFAULT_CYC + 8 && timeout_select
    |-> !watchdog_fault_n)
    else $error("watchdog fault missing");
  a_warn_width: assert property ($fell(watchdog_warn_pulse_n) |->
    (!watchdog_warn_pulse_n) [*8] ##1 watchdog_warn_pulse_n)
    else $error("warning pulse width wrong");
  a_warn_leads: assert property ($fell(watchdog_fault_n) |->
    !watchdog_warn_pulse_n && !$past(watchdog_warn_pulse_n))
    else $error("warning pulse does not lead fault");
  a_fault_clear: assert property (!watchdog_fault_n && watchdog_kick != kick_q
    |-> ##[1:6] watchdog_fault_n)
    else $error("fault not cleared by kick");
  a_wd_in_reset: assert property (!reset_n && !$past(reset_n)
    |-> watchdog_fault_n && watchdog_warn_pulse_n)
    else $error("watchdog outputs active in reset");
  a_cs_source: assert property (!chip_sel_out_n
    |-> !$past(chip_sel_in_n, 3) || !$past(chip_sel_in_n, 2))
    else $error("gated select low without request");
  a_cs_grace: assert property (low_cnt > 160 |-> chip_sel_out_n)
    else $error("gated select low past grace");
endmodule

bind csw_top csw_monitor #(.STRETCH_CYC(STRETCH_CYC), .WD_DEFAULT_CYC(WD_DEFAULT_CYC),
  .WARN_PULSE_CYC(WARN_PULSE_CYC)) i_csw_monitor (.mclk(mclk), .rst_n(rst_n),
  .supply_below_thr(supply_below_thr), .reset_sense_below(reset_sense_below),
  .mode_sense_raised(mode_sense_raised), .lowline_level(lowline_level),
  .supply_warning_sense(supply_warning_sense), .overvoltage_sense(overvoltage_sense),
  .timeout_select(timeout_select), .timeout_cap_nf(timeout_cap_nf),
  .supply_is_3v(supply_is_3v), .manual_reset_n(manual_reset_n),
  .manual_reset_driven(manual_reset_driven), .watchdog_kick(watchdog_kick),
  .chip_sel_in_n(chip_sel_in_n), .reset_n(reset_n), .reset_hi(reset_hi),
  .supply_warning_n(supply_warning_n), .overvoltage_flag_n(overvoltage_flag_n),
  .watchdog_fault_n(watchdog_fault_n), .watchdog_warn_pulse_n(watchdog_warn_pulse_n),
  .chip_sel_out_n(chip_sel_out_n));

// ===== tb/csw_top_tb.sv
// Purpose: directed test of the supervisor block at its pins
// Assumes: shortened stretch, watchdog and pulse counts
// Notes: capacitor timeouts are too long to run; only the zero value is used
`timescale 1ns/100ps
module csw_top_tb;
  localparam int STRETCH = 20;
  localparam logic [24:0] VEC = {5'h11, 5'h12, 5'h14, 5'h18, 5'h08};
  logic mclk, rst_n, supply_below_thr, reset_sense_below, mode_sense_raised, lowline_level;
  logic supply_warning_sense, overvoltage_sense, timeout_select, supply_is_3v, stray;
  logic manual_reset_n, manual_reset_driven, watchdog_kick, chip_sel_in_n, kick_en, cs_req;
  logic [csw_pkg::CAP_W-1:0] timeout_cap_nf;
  logic reset_n, reset_hi, supply_warning_n, overvoltage_flag_n, watchdog_fault_n;
  logic watchdog_warn_pulse_n, chip_sel_out_n;
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;
  int n;

  csw_top #(.STRETCH_CYC(STRETCH), .WD_DEFAULT_CYC(50), .WARN_PULSE_CYC(8)) i_csw_top (
    .mclk(mclk), .rst_n(rst_n), .supply_below_thr(supply_below_thr),
    .reset_sense_below(reset_sense_below), .mode_sense_raised(mode_sense_raised),
    .lowline_level(lowline_level), .supply_warning_sense(supply_warning_sense),
    .overvoltage_sense(overvoltage_sense), .timeout_select(timeout_select),
    .timeout_cap_nf(timeout_cap_nf), .supply_is_3v(supply_is_3v),
    .manual_reset_n(manual_reset_n), .manual_reset_driven(manual_reset_driven),
    .watchdog_kick(watchdog_kick), .chip_sel_in_n(chip_sel_in_n), .reset_n(reset_n),
    .reset_hi(reset_hi), .supply_warning_n(supply_warning_n),
    .overvoltage_flag_n(overvoltage_flag_n), .watchdog_fault_n(watchdog_fault_n),
    .watchdog_warn_pulse_n(watchdog_warn_pulse_n), .chip_sel_out_n(chip_sel_out_n));

  csw_cpu_model i_csw_cpu_model (.mclk(mclk), .rst_n(rst_n), .reset_n(reset_n),
    .kick_en(kick_en), .cs_req(cs_req), .stray(stray), .watchdog_kick(watchdog_kick),
    .chip_sel_in_n(chip_sel_in_n));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic stop_test();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
  endtask

  // reads just after the edge so the edge's own updates have landed
  task automatic chk(input logic exp, input logic act);
    #1;
    samples_checked++;
    if (act !== exp) begin
      mismatches++;
      $display("Error at %0t: expected %h got %h", $time, exp, act);
    end
  endtask

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      mismatches++;
      stop_test();
    end
  end

  initial begin
    {rst_n, supply_below_thr, reset_sense_below, mode_sense_raised, lowline_level} = '0;
    {supply_warning_sense, overvoltage_sense, supply_is_3v, stray, cs_req} = '0;
    {timeout_select, manual_reset_n, manual_reset_driven, kick_en} = '1;
    timeout_cap_nf = '0;
    cyc(2);
    rst_n <= 1'b1;
    chk(1'b1, reset_hi);
    chk(1'b1, chip_sel_out_n);
    cyc(STRETCH);
    chk(1'b0, reset_n);
    cyc(6);
    chk(1'b1, reset_n);
    supply_below_thr <= 1'b1;
    cyc(5);
    chk(1'b0, reset_n);
    chk(1'b0, supply_warning_n);
    cyc(1);
    supply_below_thr <= 1'b0;
    cyc(STRETCH);
    chk(1'b0, reset_n);
    cyc(8);
    chk(1'b1, reset_n);
    for (int i = 0; i < 5; i++) begin
      cyc(1);
      {mode_sense_raised, lowline_level, supply_warning_sense, supply_below_thr,
        reset_sense_below} <= VEC[i*5 +: 5];
      cyc(5);
      chk(1'(5'b11010 >> i), supply_warning_n);
      chk(1'(5'b01111 >> i), reset_n);
    end
    cyc(1);
    {mode_sense_raised, reset_sense_below, overvoltage_sense} <= 3'h1;
    cyc(5);
    chk(1'b0, overvoltage_flag_n);
    chk(1'b0, reset_n);
    cyc(STRETCH + 8);
    chk(1'b1, reset_n);
    overvoltage_sense <= 1'b0;
    manual_reset_n <= 1'b0;
    cyc(60);
    manual_reset_n <= 1'b1;
    cyc(100);
    chk(1'b1, reset_n);
    manual_reset_n <= 1'b0;
    cyc(110);
    chk(1'b1, reset_n);
    cyc(20);
    chk(1'b0, reset_n);
    cyc(170);
    manual_reset_n <= 1'b1;
    cyc(STRETCH);
    chk(1'b0, reset_n);
    cyc(8);
    chk(1'b1, reset_n);
    {manual_reset_driven, manual_reset_n} <= 2'h0;
    cyc(200);
    chk(1'b1, reset_n);
    {manual_reset_driven, manual_reset_n, kick_en} <= 3'h6;
    for (n = 0; n < 100 && watchdog_fault_n !== 1'b0; n++) @(negedge mclk);
    chk(1'b1, n > 35 && n < 60);
    chk(1'b0, watchdog_warn_pulse_n);
    cyc(5);
    chk(1'b0, watchdog_warn_pulse_n);
    cyc(15);
    chk(1'b0, watchdog_fault_n);
    chk(1'b1, watchdog_warn_pulse_n);
    cyc(1);
    kick_en <= 1'b1;
    cyc(16);
    chk(1'b1, watchdog_fault_n);
    {timeout_select, kick_en, supply_is_3v} <= 3'h1;
    cyc(12);
    chk(1'b0, watchdog_fault_n);
    cyc(1);
    {timeout_select, kick_en, cs_req} <= 3'h7;
    cyc(16);
    chk(1'b1, watchdog_fault_n);
    chk(1'b0, chip_sel_out_n);
    supply_below_thr <= 1'b1;
    cyc(5);
    chk(1'b0, chip_sel_out_n);
    cyc(160);
    chk(1'b1, chip_sel_out_n);
    cyc(1);
    cs_req <= 1'b0;
    cyc(5);
    {cs_req, stray} <= 2'h3;
    cyc(5);
    chk(1'b1, chip_sel_out_n);
    cyc(1);
    {cs_req, stray, supply_below_thr} <= 3'h0;
    cyc(STRETCH + 8);
    cs_req <= 1'b1;
    cyc(5);
    supply_below_thr <= 1'b1;
    cyc(19);
    chk(1'b0, chip_sel_out_n);
    cyc(1);
    cs_req <= 1'b0;
    cyc(5);
    chk(1'b1, chip_sel_out_n);
    cyc(1);
    supply_below_thr <= 1'b0;
    cyc(STRETCH + 8);
    rst_n <= 1'b0;
    cyc(1);
    chk(1'b0, reset_n);
    chk(1'b1, watchdog_fault_n);
    cyc(1);
    rst_n <= 1'b1;
    cyc(STRETCH + 60);
    chk(1'b1, watchdog_fault_n);
    stop_test();
  end
endmodule
